/* verification/cmp_core_model.sv */
/*
  Behavioural analog comparator core.
  Assumes the bench drives the input difference as a level.
*/
`timescale 1ns/100ps
module cmp_core_model
   import cmp_ctrl_pkg::*;
(
   input  wire logic        clock,
   input  wire analog_ctl_t ctl,
   input  wire logic        vin,
   output logic             raw
);
   logic flip_r = 1'b0;
   // ---------------------------------------------
   // Unpowered core output wanders every cycle
   // ---------------------------------------------
   always @(posedge clock) flip_r <= ~flip_r;
   assign raw = ctl.on ? vin : flip_r;
endmodule

/* verification/cmp_ctrl_sva.sv */
/*
  Port checker for the dual comparator control block.
  Assumes the package constants and one clock domain.
*/
`timescale 1ns/100ps
module cmp_ctrl_sva
   import cmp_ctrl_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire analog_ctl_t       cmp0_ctl,
   input wire analog_ctl_t       cmp1_ctl,
   input wire logic              comp_irq,
   input wire logic              wake_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire cfg_w = wr && addr == IDX_CONFIG;
   wire c0t_w = wr && addr == IDX_C0_COARSE;
   // ---------------------------------------------
   // Settings reach the cores; read data and wake request rules
   // ---------------------------------------------
   ch0_enable_a: assert property (
      cfg_w |-> ##2 cmp0_ctl.on == $past(wdata[7], 2))
      else $error("cmp0 enable wrong");
   ch1_enable_a: assert property (
      cfg_w |-> ##2 cmp1_ctl.on == $past(wdata[15], 2))
      else $error("cmp1 enable wrong");
   ch0_hyst_a: assert property (
      cfg_w |-> ##2 cmp0_ctl.hyst_off == $past(wdata[2], 2))
      else $error("cmp0 hysteresis wrong");
   ch1_speed_a: assert property (
      cfg_w |-> ##2 cmp1_ctl.speed == $past(wdata[9:8], 2))
      else $error("cmp1 speed wrong");
   coarse_trim_a: assert property (
      c0t_w |-> ##2 cmp0_ctl.coarse_offset == $past(wdata[4:0], 2))
      else $error("cmp0 coarse trim wrong");
   fine_valid_a: assert property (
      $past(rst_b) |-> cmp0_ctl.fine_valid ==
         (cmp0_ctl.speed == SPEED_SLOW))
      else $error("fine trim validity wrong");
   idle_rdata_a: assert property (
      !(rd && addr <= IDX_C1_FINE) |=> rdata == '0)
      else $error("read data not zero");
   wake_gate_a: assert property (
      wake_req |-> comp_irq)
      else $error("wake without masked request");
   off_quiet_a: assert property (
      (!cmp0_ctl.on && !cmp1_ctl.on) [*3] |-> !wake_req)
      else $error("wake from disabled comparators");
endmodule

bind dual_comparator_control cmp_ctrl_sva chk (.clock(clock),
   .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .cmp0_ctl(cmp0_ctl), .cmp1_ctl(cmp1_ctl),
   .comp_irq(comp_irq), .wake_req(wake_req));

/* verification/tb.sv */
/*
  Register-level testbench for the dual comparator control block.
  Assumes the core models in cmp_core_model.sv.
*/
`timescale 1ns/100ps
module tb import cmp_ctrl_pkg::*;;
   logic              clock = 0, rst_b = 0, wr = 0, rd = 0;
   logic              vin0 = 0, vin1 = 0;
   logic [ADDR_W-1:0] addr  = '0;
   logic [DATA_W-1:0] wdata = '0, v;
   logic [DATA_W-1:0] rdata;
   analog_ctl_t       c0, c1;
   logic              raw0, raw1, comp_irq, wake_req, x;
   int                n_fail = 0, checks_done = 0, cyc = 0;
   always #2.5 clock = ~clock;
   dual_comparator_control dut (.clock(clock), .rst_b(rst_b),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .cmp0_raw(raw0),
      .cmp1_raw(raw1), .rdata(rdata), .cmp0_ctl(c0), .cmp1_ctl(c1),
      .comp_irq(comp_irq), .wake_req(wake_req));
   cmp_core_model m0 (.clock(clock), .ctl(c0), .vin(vin0), .raw(raw0));
   cmp_core_model m1 (.clock(clock), .ctl(c1), .vin(vin1), .raw(raw1));
   // ---------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------
   task automatic chk(input logic [DATA_W-1:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] i, input logic [31:0] d);
      @(posedge clock) {addr, wdata, wr} <= {i, d, 1'b1};
      @(posedge clock) wr <= 0;
   endtask
   task automatic rd_chk(input logic [3:0] i, input logic [31:0] e);
      @(posedge clock) {addr, rd} <= {i, 1'b1};
      @(posedge clock) rd <= 0;
      #1 chk(rdata, e);
   endtask
   function automatic logic [7:0] half(logic o, logic [1:0] e,
                                       logic h, logic [1:0] s);
      return {o, 1'b0, e, 1'b0, h, s};
   endfunction
   task automatic close_out;
      $display("checks=%0d fails=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1;
      rd_chk(IDX_CONFIG, 0);
      rd_chk(IDX_GATE, 0);
      rd_chk(IDX_C0_COARSE, 32'h10);
      rd_chk(IDX_C1_FINE, 0);
      wr_reg(4'hF, 32'hFFFF_FFFF);
      rd_chk(4'hF, 0);
      for (int k = 0; k < 4; k++) begin
         v = {16'h0, half(1'b1, 2'(3 - k), k[1], 2'(2 - k % 3)),
              half(1'b1, 2'(k), k[0], 2'(k % 3))};
         wr_reg(IDX_CONFIG, v & 32'h7F7F);
         wr_reg(IDX_CONFIG, v);
         rd_chk(IDX_CONFIG, v);
         chk(c0.speed, k % 3);
         chk(c1.speed, 2 - k % 3);
         chk({c1.hyst_off, c0.hyst_off}, k[1:0]);
         chk(c0.fine_valid, k % 3 == 0);
      end
      rd_chk(IDX_PENDING, 0);
      wr_reg(IDX_C0_COARSE, 32'h0F);
      wr_reg(IDX_C0_FINE, 32'h9);
      wr_reg(IDX_C1_COARSE, 32'h1A);
      wr_reg(IDX_C1_FINE, 32'h7);
      rd_chk(IDX_C1_COARSE, 32'h1A);
      chk({c0.coarse_offset, c0.fine_offset}, 9'h0F9);
      chk({c1.coarse_offset, c1.fine_offset}, 9'h1A7);
      for (int e = 0; e < 4; e++) begin
         wr_reg(IDX_CONFIG, {24'h0, half(1'b1, 2'(e), 1'b0, 2'h0)});
         wr_reg(IDX_GATE, 1);
         wr_reg(IDX_PENDING, 3);
         for (int lv = 1; lv >= 0; lv--) begin
            @(posedge clock) vin0 <= lv[0];
            repeat (6) @(posedge clock);
            x = lv ? e[0] : e[1];
            rd_chk(IDX_PENDING, x);
            chk(comp_irq, x);
            chk(wake_req, x);
            wr_reg(IDX_PENDING, 1);
            rd_chk(IDX_PENDING, 0);
         end
      end
      @(posedge clock) vin0 <= 1;
      repeat (5) @(posedge clock);
      rd_chk(IDX_CONFIG, 32'hF0);
      wr_reg(IDX_GATE, 0);
      wr_reg(IDX_FORCE, 3);
      rd_chk(IDX_FORCE, 3);
      rd_chk(IDX_GATED, 0);
      chk(comp_irq, 0);
      wr_reg(IDX_GATE, 2);
      rd_chk(IDX_GATED, 2);
      chk({comp_irq, wake_req}, 2'b10);
      close_out();
   end
endmodule

/* verilog/cmp_channel.sv */
/*
  One comparator channel: synchroniser, edge detector and pending flag.
  Assumes the raw result is asynchronous to clock.
*/
`timescale 1ns/100ps
module cmp_channel
   import cmp_ctrl_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       raw_result,
   input  wire logic       on,
   input  wire logic [1:0] edge_type_sel,
   input  wire logic       clr,
   input  wire logic       force_set,
   output logic            result_r,
   output logic            pending_r
);

   logic meta_r;
   logic sync_r;
   logic rise;
   logic fall;
   logic hit;
   logic pending_nxt;

   // Synchroniser held clear while disabled
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_r   <= 1'h0;
         sync_r   <= 1'h0;
         result_r <= 1'h0;
      end else begin
         meta_r   <= on & raw_result;
         sync_r   <= on & meta_r;
         result_r <= on & sync_r;
      end
   end

   assign rise = sync_r & ~result_r;
   assign fall = ~sync_r & result_r;
   // Edge qualification
   assign hit  = on & (((edge_type_sel == EDGE_RISE) & rise) |
                       ((edge_type_sel == EDGE_FALL) & fall) |
                       ((edge_type_sel == EDGE_BOTH) & (rise | fall)));
   // Set wins over clear
   assign pending_nxt = hit | force_set | (pending_r & ~clr);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pending_r <= 1'h0;
      end else begin
         pending_r <= pending_nxt;
      end
   end

endmodule

/* verilog/cmp_ctrl_pkg.sv */
/*
  Constants, register map and carrier types for the dual comparator
  control block.
  Assumes one 200 MHz clock and a plain single-cycle register port.
*/
package cmp_ctrl_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // Register indices (byte address = 4 * index)
   localparam logic [ADDR_W-1:0] IDX_CONFIG    = 4'h0;
   localparam logic [ADDR_W-1:0] IDX_PENDING   = 4'h1;
   localparam logic [ADDR_W-1:0] IDX_FORCE     = 4'h2;
   localparam logic [ADDR_W-1:0] IDX_GATE      = 4'h3;
   localparam logic [ADDR_W-1:0] IDX_GATED     = 4'h4;
   localparam logic [ADDR_W-1:0] IDX_C0_COARSE = 4'h5;
   localparam logic [ADDR_W-1:0] IDX_C0_FINE   = 4'h6;
   localparam logic [ADDR_W-1:0] IDX_C1_COARSE = 4'h7;
   localparam logic [ADDR_W-1:0] IDX_C1_FINE   = 4'h8;

   // Config field positions; comparator 1 sits CH_STRIDE above comparator 0
   localparam int CH_STRIDE  = 8;
   localparam int SPEED_LSB  = 0;
   localparam int HYST_BIT   = 2;
   localparam int EDGE_LSB   = 4;
   localparam int RESULT_BIT = 6;
   localparam int ON_BIT     = 7;

   localparam int COARSE_W = 5;
   localparam int FINE_W   = 4;

   typedef enum logic [1:0] {
      SPEED_SLOW = 2'h0,
      SPEED_FAST = 2'h1,
      SPEED_ULP  = 2'h2
   } speed_t;

   typedef enum logic [1:0] {
      EDGE_OFF  = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_t;

   localparam logic [1:0]          SPEED_RST  = 2'h0;
   localparam logic [1:0]          EDGE_RST   = 2'h0;
   localparam logic                HYST_RST   = 1'h0;
   localparam logic [COARSE_W-1:0] COARSE_RST = 5'h10;
   localparam logic [FINE_W-1:0]   FINE_RST   = 4'h0;

   // Settings toward one analog comparator core
   typedef struct packed {
      logic                on;
      logic [1:0]          speed;
      logic                hyst_off;
      logic [COARSE_W-1:0] coarse_offset;
      logic [FINE_W-1:0]   fine_offset;
      logic                fine_valid;
   } analog_ctl_t;

   // Register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

endpackage

/* verilog/dual_comparator_control.sv */
/*
  Control and status for two low-power comparators: configuration,
  pending/force/gate registers, trim registers and the CPU request.
  Assumes a single-cycle register port and asynchronous comparator
  results from the analog cores.
*/
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
module dual_comparator_control
   import cmp_ctrl_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   input  wire logic              cmp0_raw,
   input  wire logic              cmp1_raw,
   output logic       [DATA_W-1:0] rdata,
   output analog_ctl_t            cmp0_ctl,
   output analog_ctl_t            cmp1_ctl,
   output logic                   comp_irq,
   output logic                   wake_req
);

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   reg_req_t req;
   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   wire wr_config  = req.wr & (req.addr == IDX_CONFIG);
   wire wr_pending = req.wr & (req.addr == IDX_PENDING);
   wire wr_force   = req.wr & (req.addr == IDX_FORCE);
   wire wr_gate    = req.wr & (req.addr == IDX_GATE);

   // ------------------------------------------------------------
   // Per-comparator state
   // ------------------------------------------------------------
   logic [1:0]          speed_r  [2];
   logic [1:0]          edge_r   [2];
   logic                hyst_r   [2];
   logic                on_r     [2];
   logic                gate_r   [2];
   logic [COARSE_W-1:0] coarse_r [2];
   logic [FINE_W-1:0]   fine_r   [2];
   logic                result   [2];
   logic                pending  [2];
   logic [1:0]          gated;
   logic [1:0]          armed;
   logic [DATA_W-1:0]   cfg_word;
   logic [1:0]          raw;

   assign raw = {cmp1_raw, cmp0_raw};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : ch
         localparam int B = g * CH_STRIDE;
         localparam logic [ADDR_W-1:0] IC = (g == 0) ? IDX_C0_COARSE
                                                      : IDX_C1_COARSE;
         localparam logic [ADDR_W-1:0] IF = (g == 0) ? IDX_C0_FINE
                                                      : IDX_C1_FINE;
         wire wr_coarse = req.wr & (req.addr == IC);
         wire wr_fine   = req.wr & (req.addr == IF);
         // Gate with the enable the core itself sees
         wire core_on   = (g == 0) ? cmp0_ctl.on : cmp1_ctl.on;

         // Config fields per channel
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               speed_r[g] <= SPEED_RST;
               edge_r[g]  <= EDGE_RST;
               hyst_r[g]  <= HYST_RST;
               on_r[g]    <= 1'h0;
               gate_r[g]  <= 1'h0;
               coarse_r[g] <= COARSE_RST;
               fine_r[g]  <= FINE_RST;
            end else begin
               if (wr_config) begin
                  speed_r[g] <= req.wdata[B+SPEED_LSB +: 2];
                  edge_r[g]  <= req.wdata[B+EDGE_LSB +: 2];
                  hyst_r[g]  <= req.wdata[B+HYST_BIT];
                  on_r[g]    <= req.wdata[B+ON_BIT];
               end
               if (wr_gate) begin
                  gate_r[g] <= req.wdata[g];
               end
               // Trim register pairs
               if (wr_coarse) begin
                  coarse_r[g] <= req.wdata[COARSE_W-1:0];
               end
               if (wr_fine) begin
                  fine_r[g] <= req.wdata[FINE_W-1:0];
               end
            end
         end

         cmp_channel u_chan (
            .clock         (clock),
            .rst_b         (rst_b),
            .raw_result    (raw[g]),
            .on            (core_on),
            .edge_type_sel (edge_r[g]),
            .clr           (wr_pending & req.wdata[g]),
            .force_set     (wr_force & req.wdata[g]),
            .result_r      (result[g]),
            .pending_r     (pending[g])
         );

         // Mask gating toward the CPU
         assign gated[g] = pending[g] & gate_r[g];
         // Wakeup qualification
         assign armed[g] = on_r[g] & (edge_r[g] != EDGE_OFF) & gate_r[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      cfg_word = '0;
      for (int i = 0; i < 2; i++) begin
         cfg_word[i*CH_STRIDE+SPEED_LSB +: 2] = speed_r[i];
         cfg_word[i*CH_STRIDE+HYST_BIT]       = hyst_r[i];
         cfg_word[i*CH_STRIDE+EDGE_LSB +: 2]  = edge_r[i];
         // Synchronised status bit
         cfg_word[i*CH_STRIDE+RESULT_BIT]     = result[i];
         cfg_word[i*CH_STRIDE+ON_BIT]         = on_r[i];
      end
   end

   wire [DATA_W-1:0] pend_word  = {30'h0, pending[1], pending[0]};
   wire [DATA_W-1:0] gate_word  = {30'h0, gate_r[1], gate_r[0]};
   wire [DATA_W-1:0] gated_word = {30'h0, gated};

   logic [DATA_W-1:0] rdata_nxt;
   always_comb begin
      case (req.addr)
         IDX_CONFIG:    rdata_nxt = cfg_word;
         IDX_PENDING:   rdata_nxt = pend_word;
         IDX_FORCE:     rdata_nxt = pend_word;
         IDX_GATE:      rdata_nxt = gate_word;
         IDX_GATED:     rdata_nxt = gated_word;
         IDX_C0_COARSE: rdata_nxt = {27'h0, coarse_r[0]};
         IDX_C0_FINE:   rdata_nxt = {28'h0, fine_r[0]};
         IDX_C1_COARSE: rdata_nxt = {27'h0, coarse_r[1]};
         IDX_C1_FINE:   rdata_nxt = {28'h0, fine_r[1]};
         default:       rdata_nxt = '0;
      endcase
   end

   // ------------------------------------------------------------
   // Analog settings
   // ------------------------------------------------------------
   analog_ctl_t ctl_nxt [2];
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ctl_nxt[i].on            = on_r[i];
         ctl_nxt[i].speed         = speed_r[i];
         ctl_nxt[i].hyst_off      = hyst_r[i];
         ctl_nxt[i].coarse_offset = coarse_r[i];
         ctl_nxt[i].fine_offset   = fine_r[i];
         // Fine trim only meaningful in slow mode
         ctl_nxt[i].fine_valid    = (speed_r[i] == SPEED_SLOW);
      end
   end

   // ------------------------------------------------------------
   // Output flops
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata    <= '0;
         cmp0_ctl <= '0;
         cmp1_ctl <= '0;
         comp_irq <= 1'h0;
         wake_req <= 1'h0;
      end else begin
         rdata    <= req.rd ? rdata_nxt : '0;
         cmp0_ctl <= ctl_nxt[0];
         cmp1_ctl <= ctl_nxt[1];
         comp_irq <= |gated;
         wake_req <= |(gated & armed);
      end
   end

endmodule
